// ==== psw_pkg.sv ====
package psw_pkg;
  // slow reference oscillator
  localparam int OSC_FREQ_HZ = 16384;
  localparam int CORE_FREQ_HZ = 125000000;
  // core cycles per half period of the slow reference, rounded down
  localparam int OSC_HALF_CYC = CORE_FREQ_HZ / (2 * OSC_FREQ_HZ);
  localparam int OSC_DIV_W = 12;
  // timer 0: ticks of 1/128 s (7.8125 ms), 1..128 ticks
  localparam int TMR0_TICKS_PER_STEP = 128;
  localparam int TMR0_W = 8;
  localparam logic [TMR0_W-1:0] TMR0_MIN = 8'h01;
  localparam logic [TMR0_W-1:0] TMR0_MAX = 8'h80;
  // timer 1: 1 s steps, 1..65535 s
  localparam int TMR1_TICKS_PER_STEP = 16384;
  localparam int TMR1_W = 16;
  localparam logic [TMR1_W-1:0] TMR1_MIN = 16'h0001;
  localparam int PRE_W = 14;
  // regulator settle time in slow ticks
  localparam int REG_SETTLE_TICKS = 16;
  localparam int SETTLE_W = 5;
  // retention sram window
  localparam logic [31:0] RET_SRAM_BASE = 32'h2001_a000;
  localparam logic [31:0] RET_SRAM_LAST = 32'h2001_bfff;
  typedef enum logic [2:0] {
    PSW_REG_OFF = 3'b001,
    PSW_REG_SETTLE = 3'b010,
    PSW_REG_READY = 3'b100
  } psw_reg_state_t;
endpackage

// ==== psw_slow_osc.sv ====
`timescale 1ns/1ps
// slow reference oscillator model: divider from the core clock, one tick per period
module psw_slow_osc
  import psw_pkg::*;
#(
  parameter int HALF_CYC = OSC_HALF_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  output logic o_tick
);
  initial begin
    if (HALF_CYC < 1 || HALF_CYC >= (1 << OSC_DIV_W)) $error("bad HALF_CYC");
  end
  logic [OSC_DIV_W-1:0] cnt_q, cnt_d;
  logic phase_q, phase_d, tick_d;
  always_comb begin
    cnt_d = cnt_q;
    phase_d = phase_q;
    tick_d = 1'b0;
    if (i_enable) begin
      if (cnt_q == OSC_DIV_W'(HALF_CYC - 1)) begin
        cnt_d = '0;
        phase_d = ~phase_q;
        tick_d = phase_q;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= '0;
      phase_q <= 1'b0;
      o_tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      phase_q <= phase_d;
      o_tick <= tick_d;
    end
  end
endmodule

// ==== psw_wake_timer.sv ====
`timescale 1ns/1ps
// one wake timer: prescaler of slow ticks, then a step counter
module psw_wake_timer
  import psw_pkg::*;
#(
  parameter int W = TMR1_W,
  parameter int STEP_TICKS = TMR1_TICKS_PER_STEP
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [W-1:0] i_count,
  output logic o_running,
  output logic o_expire
);
  initial begin
    if (STEP_TICKS < 1 || STEP_TICKS > (1 << PRE_W)) $error("bad STEP_TICKS");
  end
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [W-1:0] rem_q, rem_d;
  logic run_d, exp_d;
  always_comb begin
    pre_d = pre_q;
    rem_d = rem_q;
    run_d = o_running;
    exp_d = 1'b0;
    if (i_stop) begin
      run_d = 1'b0;
    end else if (i_start) begin
      run_d = 1'b1;
      pre_d = '0;
      rem_d = i_count;
    end else if (o_running && i_tick) begin
      if (pre_q == PRE_W'(STEP_TICKS - 1)) begin
        pre_d = '0;
        if (rem_q <= W'(1)) begin
          run_d = 1'b0;
          exp_d = 1'b1;
          rem_d = '0;
        end else begin
          rem_d = rem_q - 1'b1;
        end
      end else begin
        pre_d = pre_q + 1'b1;
      end
    end
  end
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_q <= '0;
      rem_q <= '0;
      o_running <= 1'b0;
      o_expire <= 1'b0;
    end else begin
      pre_q <= pre_d;
      rem_q <= rem_d;
      o_running <= run_d;
      o_expire <= exp_d;
    end
  end
endmodule

// ==== psw_top.sv ====
`timescale 1ns/1ps
// Behaviour
// - own 16.384 kHz slow reference oscillator
// - oscillator runs through all low-power modes
// - two independent wake timers, zero and one
// - both timers count slow oscillator ticks
// - timer expiry turns power switch on
// - timer zero range 7.8125 ms to 1 s
// - timer one range 1 s to 65535 s
// - sram access faults while regulator feeds it
// - retention sram 8 kB at 0x2001a000-0x2001bfff
// - ready flag rises once regulator is up
module psw_top
  import psw_pkg::*;
#(
  parameter int HALF_CYC = OSC_HALF_CYC,
  parameter int SETTLE = REG_SETTLE_TICKS
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_osc_enable_bit,
  input wire logic i_bandgap_enable_bit,
  input wire logic i_refresh_mode_bit,
  input wire logic i_retention_reg_enable_bit,
  input wire logic i_isolation_bit,
  input wire logic i_sram_supply_switch_bit,
  input wire logic [TMR0_W-1:0] i_tmr0_count,
  input wire logic [TMR1_W-1:0] i_tmr1_count,
  input wire logic i_tmr0_start,
  input wire logic i_tmr1_start,
  input wire logic i_tmr0_stop,
  input wire logic i_tmr1_stop,
  input wire logic i_tmr0_flag_clr,
  input wire logic i_tmr1_flag_clr,
  input wire logic i_switch_off,
  input wire logic i_sram_req,
  input wire logic [31:0] i_sram_addr,
  output logic o_switch_on,
  output logic o_osc_tick,
  output logic o_tmr0_running,
  output logic o_tmr1_running,
  output logic o_tmr0_flag,
  output logic o_tmr1_flag,
  output logic o_retention_reg_ready_flag,
  output logic o_refresh_active,
  output logic o_sram_on_retention,
  output logic o_sram_fault,
  output logic o_start_refused
);
  initial begin
    if (SETTLE < 1 || SETTLE >= (1 << SETTLE_W)) $error("bad SETTLE");
  end

  function automatic logic in_ret_sram(input logic [31:0] a);
    return (a >= RET_SRAM_BASE) && (a <= RET_SRAM_LAST);
  endfunction

  // ==========================================
  // slow oscillator and wake timers
  logic tick;
  logic t0_exp, t1_exp;
  logic timers_ok;
  // oscillator is gated only by its enable, never by any sleep state
  psw_slow_osc #(.HALF_CYC(HALF_CYC)) u_osc (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_enable(i_osc_enable_bit),
    .o_tick(tick)
  );

  // start refused without oscillator and bandgap, else the timer would hang
  assign timers_ok = i_osc_enable_bit && i_bandgap_enable_bit;

  logic t0_cnt_ok, t1_cnt_ok;
  assign t0_cnt_ok = (i_tmr0_count >= TMR0_MIN) && (i_tmr0_count <= TMR0_MAX);
  assign t1_cnt_ok = (i_tmr1_count >= TMR1_MIN);

  logic t0_go, t1_go;
  assign t0_go = i_tmr0_start && timers_ok && t0_cnt_ok;
  assign t1_go = i_tmr1_start && timers_ok && t1_cnt_ok;

  psw_wake_timer #(.W(TMR0_W), .STEP_TICKS(TMR0_TICKS_PER_STEP)) u_tmr0 (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick),
    .i_start(t0_go),
    .i_stop(i_tmr0_stop),
    .i_count(i_tmr0_count),
    .o_running(o_tmr0_running),
    .o_expire(t0_exp)
  );
  psw_wake_timer #(.W(TMR1_W), .STEP_TICKS(TMR1_TICKS_PER_STEP)) u_tmr1 (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick),
    .i_start(t1_go),
    .i_stop(i_tmr1_stop),
    .i_count(i_tmr1_count),
    .o_running(o_tmr1_running),
    .o_expire(t1_exp)
  );

  // ==========================================
  // sticky flags and switch state
  logic f0_d, f1_d, sw_d, refused_d;
  always_comb begin
    // set wins over a clear in the same cycle
    f0_d = t0_exp | (o_tmr0_flag & ~i_tmr0_flag_clr);
    f1_d = t1_exp | (o_tmr1_flag & ~i_tmr1_flag_clr);
    sw_d = o_switch_on;
    if (t0_exp || t1_exp) begin
      sw_d = 1'b1;
    end else if (i_switch_off) begin
      sw_d = 1'b0;
    end
    refused_d = (i_tmr0_start && !t0_go) || (i_tmr1_start && !t1_go);
  end
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tmr0_flag <= 1'b0;
      o_tmr1_flag <= 1'b0;
      o_switch_on <= 1'b1;
      o_start_refused <= 1'b0;
      o_osc_tick <= 1'b0;
    end else begin
      o_tmr0_flag <= f0_d;
      o_tmr1_flag <= f1_d;
      o_switch_on <= sw_d;
      o_start_refused <= refused_d;
      o_osc_tick <= tick;
    end
  end

  // ==========================================
  // retention regulator sequence
  psw_reg_state_t st_q, st_d;
  logic [SETTLE_W-1:0] settle_q, settle_d;
  logic rdy_d, refresh_d, reg_go;
  // regulator needs its reference chain running first
  assign reg_go = i_retention_reg_enable_bit && i_osc_enable_bit
                  && i_bandgap_enable_bit;
  always_comb begin
    st_d = st_q;
    settle_d = settle_q;
    unique case (st_q)
      PSW_REG_OFF: begin
        settle_d = '0;
        if (reg_go) begin
          st_d = PSW_REG_SETTLE;
        end
      end
      PSW_REG_SETTLE: begin
        if (!reg_go) begin
          st_d = PSW_REG_OFF;
        end else if (tick) begin
          if (settle_q == SETTLE_W'(SETTLE - 1)) begin
            st_d = PSW_REG_READY;
          end else begin
            settle_d = settle_q + 1'b1;
          end
        end
      end
      PSW_REG_READY: begin
        if (!reg_go) begin
          st_d = PSW_REG_OFF;
        end
      end
      default: begin
        st_d = PSW_REG_OFF;
      end
    endcase
    rdy_d = (st_d == PSW_REG_READY);
    // refresh mode only meaningful while the regulator runs
    refresh_d = i_refresh_mode_bit && (st_d != PSW_REG_OFF);
  end
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= PSW_REG_OFF;
      settle_q <= '0;
      o_retention_reg_ready_flag <= 1'b0;
      o_refresh_active <= 1'b0;
    end else begin
      st_q <= st_d;
      settle_q <= settle_d;
      o_retention_reg_ready_flag <= rdy_d;
      o_refresh_active <= refresh_d;
    end
  end

  // ==========================================
  // sram supply path and access guard
  logic on_ret_d, fault_d;
  always_comb begin
    // supply moves only with isolation up and the regulator ready
    on_ret_d = i_sram_supply_switch_bit && i_isolation_bit
               && o_retention_reg_ready_flag;
    fault_d = i_sram_req && in_ret_sram(i_sram_addr)
              && (o_sram_on_retention || i_isolation_bit);
  end
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sram_on_retention <= 1'b0;
      o_sram_fault <= 1'b0;
    end else begin
      o_sram_on_retention <= on_ret_d;
      o_sram_fault <= fault_d;
    end
  end
endmodule

// ==== psw_top_asserts.sv ====
`timescale 1ns/1ps
module psw_top_asserts
  import psw_pkg::*;
#(
  parameter int HALF_CYC = OSC_HALF_CYC,
  parameter int SETTLE = REG_SETTLE_TICKS
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_osc_enable_bit,
  input wire logic i_bandgap_enable_bit,
  input wire logic i_retention_reg_enable_bit,
  input wire logic i_isolation_bit,
  input wire logic i_sram_supply_switch_bit,
  input wire logic [TMR0_W-1:0] i_tmr0_count,
  input wire logic [TMR1_W-1:0] i_tmr1_count,
  input wire logic i_tmr0_start,
  input wire logic i_tmr1_start,
  input wire logic i_tmr0_stop,
  input wire logic i_tmr1_stop,
  input wire logic i_tmr0_flag_clr,
  input wire logic i_sram_req,
  input wire logic [31:0] i_sram_addr,
  input wire logic o_switch_on,
  input wire logic o_osc_tick,
  input wire logic o_tmr0_flag,
  input wire logic o_tmr1_flag,
  input wire logic o_retention_reg_ready_flag,
  input wire logic o_sram_on_retention,
  input wire logic o_sram_fault,
  input wire logic o_start_refused
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  logic hit;
  assign hit = i_sram_req && i_sram_addr >= RET_SRAM_BASE && i_sram_addr <= RET_SRAM_LAST;
  // ============================================
  // assertions
  tick_pulse_a: assert property (o_osc_tick |=> !o_osc_tick)
    else $error("tick longer than one cycle");
  flag_hold_a: assert property (
    o_tmr0_flag && !i_tmr0_flag_clr |=> o_tmr0_flag)
    else $error("expiry flag lost");
  expire_on_a: assert property ($rose(o_tmr0_flag || o_tmr1_flag) |-> o_switch_on)
    else $error("expiry without switch on");
  fault_in_a: assert property (
    hit && (o_sram_on_retention || i_isolation_bit) |=> o_sram_fault)
    else $error("missing sram fault");
  fault_out_a: assert property (!hit |=> !o_sram_fault)
    else $error("fault outside window");
  ready_drop_a: assert property (
    !i_retention_reg_enable_bit |=> !o_retention_reg_ready_flag)
    else $error("ready kept after disable");
  ready_cause_a: assert property ($rose(o_retention_reg_ready_flag) |->
    $past(i_retention_reg_enable_bit && i_osc_enable_bit && i_bandgap_enable_bit))
    else $error("ready without enables");
  refuse_a: assert property (i_tmr0_start && !i_tmr0_stop && (
    i_tmr0_count == 8'h00 || i_tmr0_count > TMR0_MAX) ||
    i_tmr1_start && !i_tmr1_stop && i_tmr1_count == 16'h0000 |=> o_start_refused)
    else $error("bad start not refused");
  on_ret_a: assert property (o_sram_on_retention |->
    $past(i_sram_supply_switch_bit && i_isolation_bit && o_retention_reg_ready_flag))
    else $error("supply moved without sequence");
endmodule
bind psw_top psw_top_asserts #(.HALF_CYC(HALF_CYC), .SETTLE(SETTLE)) u_psw_top_asserts (.*);

// ==== test_psw_top.sv ====
`timescale 1ns/1ps
module test_psw_top
  import psw_pkg::*;
;
  localparam int TP = 4;
  localparam int ST = 2;
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_osc_enable_bit = 1'b0;
  logic i_bandgap_enable_bit = 1'b0, i_refresh_mode_bit = 1'b0, i_retention_reg_enable_bit = 1'b0;
  logic i_isolation_bit = 1'b0, i_sram_supply_switch_bit = 1'b0, i_switch_off = 1'b0;
  logic [TMR0_W-1:0] i_tmr0_count = 8'h01;
  logic [TMR1_W-1:0] i_tmr1_count = 16'h0001;
  logic i_tmr0_start = 1'b0, i_tmr1_start = 1'b0, i_tmr0_stop = 1'b0, i_tmr1_stop = 1'b0;
  logic i_tmr0_flag_clr = 1'b0, i_tmr1_flag_clr = 1'b0, i_sram_req = 1'b0;
  logic [31:0] i_sram_addr = 32'h0000_0000;
  logic o_switch_on, o_osc_tick, o_tmr0_running, o_tmr1_running, o_tmr0_flag, o_tmr1_flag;
  logic o_retention_reg_ready_flag, o_refresh_active, o_sram_on_retention, o_sram_fault;
  logic o_start_refused;
  int err_total = 0;
  int checked = 0;
  int n;
  logic [31:0] a;
  psw_top #(.HALF_CYC(TP / 2), .SETTLE(ST)) u_psw_top (.*);
  initial forever #4 i_core_clk = ~i_core_clk;
  // ============================================
  // helpers
  function automatic logic in_win(input logic [31:0] x);
    return x >= RET_SRAM_BASE && x <= RET_SRAM_LAST;
  endfunction
  task automatic stp(input int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask
  task automatic chk_bit(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_cnt(input int g, input int lo, input int hi);
    checked++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h..%h", $time, g, lo, hi);
    end
  endtask
  // bounded wait; gives the count so the caller judges it
  task automatic wfor(input int sel, input int lim, output int k);
    logic s;
    k = 0;
    s = 1'b0;
    while (k < lim && s !== 1'b1) begin
      stp(1);
      k++;
      s = (sel == 0) ? o_osc_tick : (sel == 1) ? o_retention_reg_ready_flag :
          (sel == 2) ? o_tmr0_flag : o_tmr1_flag;
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic access(input logic [31:0] x);
    @(posedge i_core_clk) i_sram_req <= 1'b1;
    i_sram_addr <= x;
    @(posedge i_core_clk) i_sram_req <= 1'b0;
    #1;
    // supply only moves while isolated, so isolation alone marks the guarded span
    chk_bit(o_sram_fault, in_win(x) && i_isolation_bit);
  endtask
  initial begin
    // timer one runs one full second of slow ticks
    #(8 * 80000);
    err_total++;
    give_verdict();
  end
  // ============================================
  // main sequence
  initial begin
    void'($urandom(59));
    repeat (5) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_core_clk) i_osc_enable_bit <= 1'b1;
    i_bandgap_enable_bit <= 1'b1;
    wfor(0, 20, n);
    wfor(0, 20, n);
    chk_cnt(n, TP, TP);
    @(posedge i_core_clk) i_refresh_mode_bit <= 1'b1;
    i_retention_reg_enable_bit <= 1'b1;
    wfor(1, 64, n);
    chk_cnt(n, (ST - 1) * TP, ST * TP + 3);
    chk_bit(o_refresh_active, 1'b1);
    @(posedge i_core_clk) i_isolation_bit <= 1'b1;
    @(posedge i_core_clk) i_sram_supply_switch_bit <= 1'b1;
    stp(3);
    chk_bit(o_sram_on_retention, 1'b1);
    access(RET_SRAM_BASE);
    access(RET_SRAM_LAST);
    access(RET_SRAM_BASE - 32'h1);
    access(RET_SRAM_LAST + 32'h1);
    for (int i = 0; i < 20; i++) access(32'h2001_9000 + $urandom_range(0, 32'h3fff));
    @(posedge i_core_clk) i_sram_supply_switch_bit <= 1'b0;
    // still isolated while the supply swings back
    access(RET_SRAM_BASE + 32'h10);
    @(posedge i_core_clk) i_isolation_bit <= 1'b0;
    stp(3);
    chk_bit(o_sram_on_retention, 1'b0);
    access(RET_SRAM_BASE);
    @(posedge i_core_clk) i_retention_reg_enable_bit <= 1'b0;
    stp(2);
    chk_bit(o_retention_reg_ready_flag, 1'b0);
    @(posedge i_core_clk) i_switch_off <= 1'b1;
    @(posedge i_core_clk) i_switch_off <= 1'b0;
    stp(1);
    chk_bit(o_switch_on, 1'b0);
    // zero count, over-range, timer one zero, bandgap off
    for (int k = 0; k < 4; k++) begin
      @(posedge i_core_clk) i_tmr0_count <= (k == 1) ? 8'h81 : {7'h00, k == 3};
      i_bandgap_enable_bit <= (k != 3);
      i_tmr1_count <= 16'h0000;
      i_tmr0_start <= (k != 2);
      i_tmr1_start <= (k == 2);
      @(posedge i_core_clk) i_tmr0_start <= 1'b0;
      i_tmr1_start <= 1'b0;
      #1;
      chk_bit(o_start_refused, 1'b1);
      chk_bit(o_tmr0_running | o_tmr1_running, 1'b0);
    end
    @(posedge i_core_clk) i_bandgap_enable_bit <= 1'b1;
    i_tmr0_count <= TMR0_MAX;
    i_tmr0_start <= 1'b1;
    @(posedge i_core_clk) i_tmr0_start <= 1'b0;
    i_tmr0_stop <= 1'b1;
    #1;
    chk_bit(o_tmr0_running, 1'b1);
    chk_bit(o_start_refused, 1'b0);
    @(posedge i_core_clk) i_tmr0_stop <= 1'b0;
    i_tmr0_count <= 8'h02;
    @(posedge i_core_clk) i_tmr0_start <= 1'b1;
    @(posedge i_core_clk) i_tmr0_start <= 1'b0;
    #1;
    chk_bit(o_tmr0_running, 1'b1);
    wfor(2, 1200, n);
    chk_cnt(n, 2 * TMR0_TICKS_PER_STEP * TP - TP, 2 * TMR0_TICKS_PER_STEP * TP + 4);
    chk_bit(o_switch_on, 1'b1);
    stp(5);
    chk_bit(o_tmr0_flag, 1'b1);
    @(posedge i_core_clk) i_tmr0_flag_clr <= 1'b1;
    @(posedge i_core_clk) i_tmr0_flag_clr <= 1'b0;
    stp(1);
    chk_bit(o_tmr0_flag, 1'b0);
    @(posedge i_core_clk) i_tmr1_count <= 16'($urandom_range(1, 65535));
    i_tmr1_start <= 1'b1;
    @(posedge i_core_clk) i_tmr1_start <= 1'b0;
    stp(1);
    chk_bit(o_tmr1_running, 1'b1);
    @(posedge i_core_clk) i_tmr1_stop <= 1'b1;
    @(posedge i_core_clk) i_tmr1_stop <= 1'b0;
    stp(1);
    chk_bit(o_tmr1_running, 1'b0);
    // switch off, then let timer one bring it back after one step
    @(posedge i_core_clk) i_switch_off <= 1'b1;
    i_tmr1_count <= TMR1_MIN;
    i_tmr1_start <= 1'b1;
    @(posedge i_core_clk) i_switch_off <= 1'b0;
    i_tmr1_start <= 1'b0;
    stp(1);
    chk_bit(o_switch_on, 1'b0);
    wfor(3, 70000, n);
    chk_cnt(n, TMR1_TICKS_PER_STEP * TP - TP, TMR1_TICKS_PER_STEP * TP + 4);
    chk_bit(o_switch_on, 1'b1);
    chk_bit(o_tmr1_running, 1'b0);
    stp(3);
    chk_bit(o_tmr1_flag, 1'b1);
    @(posedge i_core_clk) i_tmr1_flag_clr <= 1'b1;
    @(posedge i_core_clk) i_tmr1_flag_clr <= 1'b0;
    stp(1);
    chk_bit(o_tmr1_flag, 1'b0);
    give_verdict();
  end
endmodule
